// *** inc/tmr_pkg.sv ***
// Constants shared by the one-shot / PWM timer channel.
// Assumes one core clock drives the counter; no clock prescaling.
// Behaviour
// - Mode field 011 selects one-shot pulse operation.
// - In one-shot, run bit only arms; external edge or software trigger starts.
// - Trigger moves counter FFFFH to 0000H, counts, and gives one pulse.
// - After the pulse the counter reloads FFFFH, halts, awaits next trigger.
// - Triggers arriving during a one-shot pulse are ignored.
// - One-shot delay is compare 1; width is compare 0 minus compare 1 plus 1.
// - One-shot output 0 is active while counting, inactive while awaiting trigger.
// - One-shot: compare 1 match asserts output 1; compare 0 ends pulse, stops.
// - One-shot compare values are unbuffered; lower rewrite wraps through FFFFH.
// - Compare 1 interrupt fires in the match clock, aligned with output 1.
// - Mode field 100 selects continuous PWM operation.
// - PWM: run bit clears counter to 0000H and starts at once.
// - PWM period is compare 0 plus 1; active width is compare 1.
// - PWM output 0 toggles every PWM period, a square wave.
// - PWM: count equal to shadow 0 clears counter, compare 0 interrupt follows.
// - Shadows load from registers at start, then only at a clear armed by compare 1 write.
// - Armed copy happens with the period clear; shadows drive the compares.
// - Compare 1 of 0000H gives 0% duty; interrupt still periodic.
// - Compare 1 equal compare 0 plus one gives 100%; impossible at FFFFH.
// - Counter value is readable at any time without disturbing counting.
package tmr_pkg;
    localparam int          CNT_W         = 16;
    localparam logic [2:0]  MODE_ONE_SHOT = 3'h3;
    localparam logic [2:0]  MODE_PWM      = 3'h4;
    localparam logic [15:0] COUNT_IDLE    = 16'hffff;
    localparam logic [15:0] COUNT_START   = 16'h0000;
    localparam logic [15:0] SHADOW_RESET  = 16'h0000;
    localparam logic [1:0]  EDGE_NONE     = 2'h0;
    localparam logic [1:0]  EDGE_RISE     = 2'h1;
    localparam logic [1:0]  EDGE_FALL     = 2'h2;
    localparam logic [1:0]  EDGE_BOTH     = 2'h3;
endpackage : tmr_pkg

// *** design/trig_edge_detect.sv ***
// External trigger synchroniser and selectable edge detector.
// Assumes the trigger pin is asynchronous to the core clock.
`timescale 1ns/1ps
module trig_edge_detect (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_trig_pin,
    input  wire logic [1:0] i_trig_edge,
    output logic            o_trig_pulse
);
    import tmr_pkg::*;

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic rise;
    logic fall;

    ////////////////////////////////////////////////////////////////////////////
    // Two stages before any logic looks at the pin
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= i_trig_pin;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rise = sync2_ff & ~prev_ff;
    assign fall = ~sync2_ff & prev_ff;

    always_comb begin
        case (i_trig_edge)
            EDGE_RISE: o_trig_pulse = rise;
            EDGE_FALL: o_trig_pulse = fall;
            EDGE_BOTH: o_trig_pulse = rise | fall;
            default:   o_trig_pulse = 1'b0;
        endcase
    end
endmodule : trig_edge_detect

// *** design/compare_shadow.sv ***
// Buffered copies of both compare registers for PWM mode.
// Assumes the caller signals the period clear and the channel start.
`timescale 1ns/1ps
module compare_shadow #(
    parameter int W = 16
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_compare_register_0,
    input  wire logic [W-1:0] i_compare_register_1,
    input  wire logic         i_cr1_write,
    input  wire logic         i_period_clear,
    input  wire logic         i_start,
    output logic [W-1:0]      o_shadow0,
    output logic [W-1:0]      o_shadow1,
    output logic [W-1:0]      o_next_shadow1
);
    import tmr_pkg::*;

    logic armed_ff;
    logic load;

    ////////////////////////////////////////////////////////////////////////////
    // Only a compare 1 write arms the copy; compare 0 alone stays pending
    assign load = i_start | (armed_ff & i_period_clear);
    assign o_next_shadow1 = load ? i_compare_register_1 : o_shadow1;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            armed_ff <= 1'b0;
        end else if (i_cr1_write) begin
            armed_ff <= 1'b1;
        end else if (load) begin
            armed_ff <= 1'b0;
        end
    end

    // A write colliding with the copy is undefined by contract; write wins here
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_shadow0 <= W'(SHADOW_RESET);
            o_shadow1 <= W'(SHADOW_RESET);
        end else if (load) begin
            o_shadow0 <= i_compare_register_0;
            o_shadow1 <= i_compare_register_1;
        end
    end
endmodule : compare_shadow

// *** design/timer_oneshot_pwm.sv ***
// One 16-bit timer channel in one-shot pulse and PWM output modes.
// Assumes the count clock is the core clock and that control inputs
// come from registers on the same clock; only the trigger pin is async.
`timescale 1ns/1ps
module timer_oneshot_pwm (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_counter_run_bit,
    input  wire logic [2:0]                i_operating_mode_field,
    input  wire logic                      i_software_trigger_bit,
    input  wire logic [tmr_pkg::CNT_W-1:0] i_compare_register_0,
    input  wire logic [tmr_pkg::CNT_W-1:0] i_compare_register_1,
    input  wire logic                      i_cr1_write,
    input  wire logic                      i_ext_trigger,
    input  wire logic [1:0]                i_trigger_edge_control,
    input  wire logic                      i_out0_enable,
    input  wire logic                      i_out0_active_low,
    input  wire logic                      i_out1_enable,
    input  wire logic                      i_out1_active_low,
    output logic                           o_compare_output_0,
    output logic                           o_compare_output_1,
    output logic                           o_compare0_interrupt,
    output logic                           o_compare1_interrupt,
    output logic                           o_running,
    output logic [tmr_pkg::CNT_W-1:0]      o_counter_read_buffer
);
    import tmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_TRIG,
        ST_COUNT
    } state_t;

    state_t              state_ff;
    state_t              nxt_state;
    logic [CNT_W-1:0]    count_ff;
    logic [CNT_W-1:0]    nxt_count;
    logic                act0_ff;
    logic                nxt_act0;
    logic                act1_ff;
    logic                nxt_act1;
    logic                cc0_ff;
    logic                nxt_cc0;
    logic                cc1_ff;
    logic                nxt_cc1;
    logic                pin0_ff;
    logic                pin1_ff;
    logic                ext_pulse;
    logic                trigger;
    logic                mode_os;
    logic                mode_pwm;
    logic                start;
    logic                period_clear;
    logic [CNT_W-1:0]    shadow0;
    logic [CNT_W-1:0]    shadow1;
    logic [CNT_W-1:0]    next_shadow1;
    logic [CNT_W-1:0]    cmp0;
    logic [CNT_W-1:0]    cmp1;

    // Disabled outputs are held low regardless of polarity
    function automatic logic pin_level(input logic en, input logic low, input logic act);
        pin_level = en & (act ^ low);
    endfunction : pin_level

    ////////////////////////////////////////////////////////////////////////////
    // Sub-blocks
    trig_edge_detect u_trig (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (i_rst_n),
        .i_trig_pin   (i_ext_trigger),
        .i_trig_edge  (i_trigger_edge_control),
        .o_trig_pulse (ext_pulse)
    );

    compare_shadow #(
        .W (CNT_W)
    ) u_shadow (
        .i_core_clk           (i_core_clk),
        .i_rst_n              (i_rst_n),
        .i_compare_register_0 (i_compare_register_0),
        .i_compare_register_1 (i_compare_register_1),
        .i_cr1_write          (i_cr1_write),
        .i_period_clear       (period_clear),
        .i_start              (start),
        .o_shadow0            (shadow0),
        .o_shadow1            (shadow1),
        .o_next_shadow1       (next_shadow1)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and compare source
    assign mode_os  = (i_operating_mode_field == MODE_ONE_SHOT);
    assign mode_pwm = (i_operating_mode_field == MODE_PWM);
    assign trigger  = ext_pulse | i_software_trigger_bit;

    // One-shot compares the live registers so a rewrite acts at once
    assign cmp0 = mode_os ? i_compare_register_0 : shadow0;
    assign cmp1 = mode_os ? i_compare_register_1 : shadow1;

    assign start        = mode_pwm && i_counter_run_bit && (state_ff != ST_COUNT);
    assign period_clear = mode_pwm && (state_ff == ST_COUNT) && (count_ff == cmp0);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        nxt_act0  = act0_ff;
        nxt_act1  = act1_ff;
        nxt_cc0   = 1'b0;
        nxt_cc1   = 1'b0;
        if (!i_counter_run_bit || !(mode_os || mode_pwm)) begin
            nxt_state = ST_IDLE;
            nxt_count = COUNT_IDLE;
            nxt_act0  = 1'b0;
            nxt_act1  = 1'b0;
        end else if (mode_os) begin
            case (state_ff)
                ST_COUNT: begin
                    // Triggers are not looked at while the pulse runs
                    if (count_ff == cmp0) begin
                        nxt_state = ST_WAIT_TRIG;
                        nxt_count = COUNT_IDLE;
                        nxt_act0  = 1'b0;
                        nxt_act1  = 1'b0;
                        nxt_cc0   = 1'b1;
                    end else begin
                        nxt_count = count_ff + 16'h0001;
                        if (nxt_count == cmp1) begin
                            nxt_act1 = 1'b1;
                            nxt_cc1  = 1'b1;
                        end
                    end
                end
                ST_IDLE, ST_WAIT_TRIG: begin
                    nxt_state = ST_WAIT_TRIG;
                    nxt_count = COUNT_IDLE;
                    nxt_act0  = 1'b0;
                    nxt_act1  = 1'b0;
                    if (trigger) begin
                        nxt_state = ST_COUNT;
                        nxt_count = COUNT_START;
                        nxt_act0  = 1'b1;
                        // Zero delay asserts output 1 with the trigger
                        if (cmp1 == COUNT_START) begin
                            nxt_act1 = 1'b1;
                            nxt_cc1  = 1'b1;
                        end
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end else begin
            case (state_ff)
                ST_COUNT: begin
                    if (period_clear) begin
                        nxt_count = COUNT_START;
                        nxt_cc0   = 1'b1;
                        nxt_act0  = ~act0_ff;
                        // New shadow takes effect for the period now starting
                        nxt_act1  = (next_shadow1 != COUNT_START);
                        nxt_cc1   = (next_shadow1 == COUNT_START);
                    end else begin
                        nxt_count = count_ff + 16'h0001;
                        // D1 = D0 + 1 is never reached, so output 1 stays on
                        if (nxt_count == cmp1) begin
                            nxt_act1 = 1'b0;
                            nxt_cc1  = 1'b1;
                        end
                    end
                end
                ST_IDLE, ST_WAIT_TRIG: begin
                    nxt_state = ST_COUNT;
                    nxt_count = COUNT_START;
                    nxt_act0  = 1'b0;
                    nxt_act1  = (i_compare_register_1 != COUNT_START);
                    nxt_cc1   = (i_compare_register_1 == COUNT_START);
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing state and counter
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= ST_IDLE;
            count_ff <= COUNT_IDLE;
        end else begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
        end
    end

    // Logical output levels, before polarity and enable
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act0_ff <= 1'b0;
            act1_ff <= 1'b0;
        end else begin
            act0_ff <= nxt_act0;
            act1_ff <= nxt_act1;
        end
    end

    // Interrupt pulses, one clock each
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cc0_ff <= 1'b0;
            cc1_ff <= 1'b0;
        end else begin
            cc0_ff <= nxt_cc0;
            cc1_ff <= nxt_cc1;
        end
    end

    // Pin flops see the same next level, so edges align with interrupts
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin0_ff <= 1'b0;
            pin1_ff <= 1'b0;
        end else begin
            pin0_ff <= pin_level(i_out0_enable, i_out0_active_low, nxt_act0);
            pin1_ff <= pin_level(i_out1_enable, i_out1_active_low, nxt_act1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_compare_output_0    = pin0_ff;
    assign o_compare_output_1    = pin1_ff;
    assign o_compare0_interrupt  = cc0_ff;
    assign o_compare1_interrupt  = cc1_ff;
    assign o_counter_read_buffer = count_ff;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_running <= 1'b0;
        end else begin
            o_running <= (nxt_state == ST_COUNT);
        end
    end
endmodule : timer_oneshot_pwm

// *** sim/trig_load.sv ***
// Far-side model: trigger source on the pin and a load counting pulses.
// Assumes the bench strobes i_fire for one cycle just after a clock edge.
`timescale 1ns/1ps
module trig_load (
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_fire,
    input  wire logic i_load,
    output logic      o_trig_pin,
    output logic [7:0] o_pulse_cnt
);
    logic [2:0] hold_ff;
    logic       load_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // Pin held four cycles so the synchroniser cannot miss it
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_ff     <= 3'h0;
            load_ff     <= 1'b0;
            o_pulse_cnt <= 8'h00;
        end else begin
            hold_ff <= i_fire ? 3'h4 : (hold_ff != 3'h0 ? hold_ff - 3'h1 : 3'h0);
            load_ff <= i_load;
            if (i_load && !load_ff) begin
                o_pulse_cnt <= o_pulse_cnt + 8'h01;
            end
        end
    end
    assign o_trig_pin = i_rst_n && (hold_ff != 3'h0);
endmodule : trig_load

// *** sim/timer_checker.sv ***
// Port-level assertions for the one-shot / PWM timer channel.
// Assumes it is bound to the channel; sees only its ports.
`timescale 1ns/1ps
module timer_checker (
    input wire logic                      i_core_clk,
    input wire logic                      i_rst_n,
    input wire logic                      i_counter_run_bit,
    input wire logic [2:0]                i_operating_mode_field,
    input wire logic [tmr_pkg::CNT_W-1:0] i_compare_register_0,
    input wire logic [tmr_pkg::CNT_W-1:0] i_compare_register_1,
    input wire logic                      i_out0_enable,
    input wire logic                      i_out0_active_low,
    input wire logic                      i_out1_enable,
    input wire logic                      i_out1_active_low,
    input wire logic                      o_compare_output_0,
    input wire logic                      o_compare_output_1,
    input wire logic                      o_compare0_interrupt,
    input wire logic                      o_compare1_interrupt,
    input wire logic                      o_running,
    input wire logic [tmr_pkg::CNT_W-1:0] o_counter_read_buffer
);
    import tmr_pkg::*;
    logic os_m, pwm_m, out1_plain;
    assign os_m       = (i_operating_mode_field == MODE_ONE_SHOT);
    assign pwm_m      = (i_operating_mode_field == MODE_PWM);
    assign out1_plain = i_out1_enable && !i_out1_active_low;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    AST_IDLE_COUNT: assert property (!o_running |-> o_counter_read_buffer == COUNT_IDLE)
        else $error("stopped counter not at top value");
    AST_STEP: assert property (o_running && $past(o_running)
        && o_counter_read_buffer != COUNT_START
        |-> o_counter_read_buffer == $past(o_counter_read_buffer) + 16'h0001)
        else $error("counter did not step by one");
    AST_START: assert property ($rose(o_running)
        |-> o_counter_read_buffer == COUNT_START)
        else $error("count did not start from zero");
    // Pin flop used last cycle's polarity, so compare against its past value
    AST_OS_OUT0: assert property (os_m && i_counter_run_bit && i_out0_enable
        |-> o_compare_output_0 == (o_running ^ $past(i_out0_active_low)))
        else $error("one-shot output 0 not tracking count");
    AST_OS_CC1: assert property (o_compare1_interrupt && os_m
        && out1_plain |-> o_compare_output_1 && o_counter_read_buffer == i_compare_register_1)
        else $error("one-shot compare 1 event misplaced");
    AST_OS_CC0: assert property (o_compare0_interrupt && os_m |-> !o_running
        && $past(o_counter_read_buffer) == $past(i_compare_register_0))
        else $error("one-shot compare 0 event misplaced");
    AST_PWM_CLEAR: assert property (o_compare0_interrupt && pwm_m
        |-> o_counter_read_buffer == COUNT_START)
        else $error("period end without counter clear");
    AST_PWM_OUT0: assert property (o_compare0_interrupt && pwm_m && i_out0_enable
        && $past(i_out0_enable) |-> o_compare_output_0 != $past(o_compare_output_0))
        else $error("output 0 did not toggle at period end");
    AST_PWM_CC1: assert property (o_compare1_interrupt && pwm_m && out1_plain
        |-> !o_compare_output_1)
        else $error("compare 1 event not at output 1 fall");
endmodule : timer_checker
bind timer_oneshot_pwm timer_checker timer_checker_i (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_counter_run_bit(i_counter_run_bit),
    .i_operating_mode_field(i_operating_mode_field), .i_compare_register_0(i_compare_register_0),
    .i_compare_register_1(i_compare_register_1), .i_out0_enable(i_out0_enable),
    .i_out0_active_low(i_out0_active_low),
    .i_out1_enable(i_out1_enable), .i_out1_active_low(i_out1_active_low),
    .o_compare_output_0(o_compare_output_0), .o_compare_output_1(o_compare_output_1),
    .o_compare0_interrupt(o_compare0_interrupt), .o_compare1_interrupt(o_compare1_interrupt),
    .o_running(o_running), .o_counter_read_buffer(o_counter_read_buffer));

// *** sim/tb.sv ***
// Self-checking bench for the timer channel: table of cases, then hand tests.
// Assumes the trigger/load model beside the channel and the bound checker.
`timescale 1ns/1ps
module tb;
    import tmr_pkg::*;
    typedef struct {logic [2:0] mode; logic [15:0] c0, c1, ea, eb;} row_t;
    logic        i_core_clk = 1'b0, i_rst_n = 1'b0, i_counter_run_bit = 1'b0, fire = 1'b0;
    logic        i_software_trigger_bit = 1'b0, i_cr1_write = 1'b0, i_ext_trigger;
    logic [2:0]  i_operating_mode_field = 3'h0;
    logic [15:0] i_compare_register_0 = 16'h0000, i_compare_register_1 = 16'h0000;
    logic [1:0]  i_trigger_edge_control = EDGE_RISE;
    logic        i_out0_enable = 1'b1, i_out0_active_low = 1'b0;
    logic        i_out1_enable = 1'b1, i_out1_active_low = 1'b0;
    logic        o_compare_output_0, o_compare_output_1, o_compare0_interrupt;
    logic        o_compare1_interrupt, o_running;
    logic [15:0] o_counter_read_buffer;
    logic [7:0]  pulse_cnt;
    int          error_cnt = 0, num_checks = 0, per, hi, lo, n;
    row_t        rows [7];
    timer_oneshot_pwm timer_oneshot_pwm_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_counter_run_bit(i_counter_run_bit), .i_operating_mode_field(i_operating_mode_field),
        .i_software_trigger_bit(i_software_trigger_bit), .i_cr1_write(i_cr1_write),
        .i_compare_register_0(i_compare_register_0), .i_compare_register_1(i_compare_register_1),
        .i_ext_trigger(i_ext_trigger), .i_trigger_edge_control(i_trigger_edge_control),
        .i_out0_enable(i_out0_enable), .i_out0_active_low(i_out0_active_low),
        .i_out1_enable(i_out1_enable), .i_out1_active_low(i_out1_active_low),
        .o_compare_output_0(o_compare_output_0), .o_compare_output_1(o_compare_output_1),
        .o_compare0_interrupt(o_compare0_interrupt), .o_compare1_interrupt(o_compare1_interrupt),
        .o_running(o_running), .o_counter_read_buffer(o_counter_read_buffer));
    trig_load trig_load_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_fire(fire),
        .i_load(o_compare_output_1), .o_trig_pin(i_ext_trigger), .o_pulse_cnt(pulse_cnt));
    always #4 i_core_clk = ~i_core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(posedge i_core_clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    // Stop first: lowering values mid-count would wrap the counter
    task automatic setup(input logic [2:0] m, input logic [15:0] c0, input logic [15:0] c1);
        i_counter_run_bit = 1'b0;
        tick;
        i_operating_mode_field = m;
        i_compare_register_0 = c0;
        i_compare_register_1 = c1;
        i_counter_run_bit = 1'b1;
        tick;
    endtask : setup
    task automatic os_pulse;
        i_software_trigger_bit = 1'b1;
        tick;
        i_software_trigger_bit = 1'b0;
        lo = 0;
        hi = 0;
        n = 0;
        while (o_running === 1'b1 && n < 300) begin
            if (o_compare_output_1 === 1'b1) hi++;
            else if (hi == 0) lo++;
            tick;
            n++;
        end
    endtask : os_pulse
    // Measures the period that starts at the next counter clear
    task automatic pwm_period;
        n = 0;
        while (o_compare0_interrupt !== 1'b1 && n < 300) begin
            tick;
            n++;
        end
        per = 0;
        hi = 0;
        do begin
            hi += (o_compare_output_1 === 1'b1);
            per++;
            tick;
        end while (o_compare0_interrupt !== 1'b1 && per < 300);
    endtask : pwm_period
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{MODE_ONE_SHOT, 16'h0004, 16'h0002, 16'h0002, 16'h0003};
        rows[1] = '{MODE_ONE_SHOT, 16'h0005, 16'h0000, 16'h0000, 16'h0006};
        rows[2] = '{MODE_ONE_SHOT, 16'h0003, 16'h0003, 16'h0003, 16'h0001};
        rows[3] = '{MODE_PWM, 16'h0003, 16'h0002, 16'h0004, 16'h0002};
        rows[4] = '{MODE_PWM, 16'h0004, 16'h0000, 16'h0005, 16'h0000};
        rows[5] = '{MODE_PWM, 16'h0003, 16'h0004, 16'h0004, 16'h0004};
        rows[6] = '{MODE_PWM, 16'h0000, 16'h0001, 16'h0001, 16'h0001};
        repeat (3) @(posedge i_core_clk);
        #1;
        i_rst_n = 1'b1;
        check("idle count", o_counter_read_buffer, COUNT_IDLE);
        check("idle out1", 16'(o_compare_output_1), 16'h0000);
        foreach (rows[r]) begin
            setup(rows[r].mode, rows[r].c0, rows[r].c1);
            if (rows[r].mode == MODE_ONE_SHOT) begin
                repeat (4) tick;
                check("armed", 16'(o_running), 16'h0000);
                os_pulse;
                check("delay", 16'(lo), rows[r].ea);
                check("width", 16'(hi), rows[r].eb);
                check("reload", o_counter_read_buffer, COUNT_IDLE);
            end else begin
                pwm_period;
                check("period", 16'(per), rows[r].ea);
                check("active", 16'(hi), rows[r].eb);
            end
        end
        i_out0_active_low = 1'b1;
        setup(MODE_ONE_SHOT, 16'h0008, 16'h0003);
        n = pulse_cnt;
        fire = 1'b1;
        tick;
        fire = 1'b0;
        repeat (6) tick;
        check("ext start", 16'(o_running), 16'h0001);
        check("ext cc1", 16'(o_compare1_interrupt), 16'h0001);
        check("ext out1", 16'(o_compare_output_1), 16'h0001);
        check("out0 low", 16'(o_compare_output_0), 16'h0000);
        fire = 1'b1;
        tick;
        fire = 1'b0;
        repeat (12) tick;
        check("one pulse", 16'(pulse_cnt - n[7:0]), 16'h0001);
        i_trigger_edge_control = EDGE_NONE;
        fire = 1'b1;
        tick;
        fire = 1'b0;
        repeat (8) tick;
        check("no edge", 16'(o_running), 16'h0000);
        // Falling edge only: the leading rise must not start the pulse
        i_trigger_edge_control = EDGE_FALL;
        fire = 1'b1;
        tick;
        fire = 1'b0;
        repeat (3) tick;
        check("rise ignored", 16'(o_running), 16'h0000);
        repeat (4) tick;
        check("fall start", 16'(o_running), 16'h0001);
        setup(MODE_PWM, 16'h0003, 16'h0002);
        pwm_period;
        i_compare_register_1 = 16'h0001;
        pwm_period;
        check("no copy", 16'(hi), 16'h0002);
        // Written just after a period end, compare 0 first
        i_compare_register_0 = 16'h0005;
        i_cr1_write = 1'b1;
        tick;
        i_cr1_write = 1'b0;
        pwm_period;
        check("new period", 16'(per), 16'h0006);
        check("new active", 16'(hi), 16'h0001);
        i_out1_active_low = 1'b1;
        i_out0_enable = 1'b0;
        i_compare_register_1 = 16'h0006;
        i_cr1_write = 1'b1;
        tick;
        i_cr1_write = 1'b0;
        pwm_period;
        pwm_period;
        check("low active", 16'(hi), 16'h0000);
        check("out0 off", 16'(o_compare_output_0), 16'h0000);
        // Reset in mid-run; run stays high so PWM restarts on release
        i_rst_n = 1'b0;
        tick;
        check("reset count", o_counter_read_buffer, COUNT_IDLE);
        check("reset out1", 16'(o_compare_output_1), 16'h0000);
        i_rst_n = 1'b1;
        tick;
        check("restart", o_counter_read_buffer, COUNT_START);
        complete_run;
    end
    initial begin
        #(8 * 5000);
        error_cnt++;
        complete_run;
    end
endmodule : tb
